// File: inc/dcfifo_pkg.sv
package dcfifo_pkg;

	// storage geometry
	localparam int          DATA_W      = 18;
	localparam int          PTR_W       = 16;
	localparam int          ADDR_W      = 15;
	localparam int          OFF_W       = 15;
	localparam logic [15:0] DEPTH       = 16'h8000;
	localparam logic [15:0] HALF_DEPTH  = 16'h4000;

	// default flag offsets picked by the load strap at reset
	localparam logic [14:0] OFF_DEF_PAR = 15'h007F;
	localparam logic [14:0] OFF_DEF_SER = 15'h03FF;

	// serial offset load walks two offsets of OFF_W bits each
	localparam logic [4:0]  SER_SPLIT   = 5'h0F;
	localparam logic [4:0]  SER_LAST    = 5'h1D;

	// fixed latency, in ns and in clk_in cycles (rounded up, at least one)
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          LATENCY_NS    = 60;
	localparam int          LAT_RAW       = (LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          LAT_CYC       = (LAT_RAW < 1) ? 1 : LAT_RAW;
	localparam logic [1:0]  LAT_LAST      = 2'(LAT_CYC - 1);

	// read edges needed to finish a retransmit, per mode
	localparam logic [1:0]  RETX_EDGES_STD  = 2'h1;
	localparam logic [1:0]  RETX_EDGES_FALL_THROUGH_MODE = 2'h2;

	// apb register byte addresses
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_AE_OFF = 12'h004;
	localparam logic [11:0] ADDR_AF_OFF = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00C;
	localparam logic [11:0] ADDR_LEVEL  = 12'h010;

	// control register fields
	localparam int          CTRL_FALL_THROUGH_MODE   = 0;
	localparam int          CTRL_PRST   = 1;
	localparam int          CTRL_RETX   = 2;
	localparam logic        CTRL_FALL_THROUGH_MODE_RST = 1'b0;

	// status register fields (active high)
	localparam int          ST_EMPTY    = 0;
	localparam int          ST_FULL     = 1;
	localparam int          ST_AE       = 2;
	localparam int          ST_AF       = 3;
	localparam int          ST_HF       = 4;
	localparam int          ST_OV       = 5;
	localparam int          ST_RETX     = 6;

	typedef enum logic [2:0]
	{
		RETX_IDLE = 3'b001,
		RETX_WAIT = 3'b010,
		RETX_EDGE = 3'b100
	} retx_state_t;

	// words between two pointers, modulo the pointer width
	function automatic logic [PTR_W-1:0] fill_level(input logic [PTR_W-1:0] head, input logic [PTR_W-1:0] tail);
		return head - tail;
	endfunction

endpackage

// File: rtl/ptr_view.sv
`timescale 1ns/1ps
// pointer copy held for the far side, refreshed on that side's edge pulse
module ptr_view
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// control
	input  wire logic        clear_in,
	input  wire logic        sample_in,
	// pointer
	input  wire logic [15:0] ptr_in,
	output logic      [15:0] ptr_out
);

	logic [15:0] ptr_q;
	logic [15:0] ptr_d;

	// clear wins so a partial reset leaves both views consistent
	always_comb
	begin
		ptr_d = ptr_q;
		if (clear_in)
			ptr_d = 16'h0000;
		else if (sample_in)
			ptr_d = ptr_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			ptr_q <= 16'h0000;
		else
			ptr_q <= ptr_d;
	end

	assign ptr_out = ptr_q;

endmodule

// File: rtl/dual_clock_fifo.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Functional notes
// - standard mode: full flag releases one write cycle after next write edge
// - standard mode: empty flag releases one read cycle after next read edge
// - standard mode: first word readable after 60 ns, flag delay, one read period
// - fall-through: output-ready goes low some read cycles after writing empty fifo
// - fall-through: first word on outputs after 60 ns plus two read periods
// - almost-empty releases one read cycle after level rises past threshold
// - fall-through: input-ready asserts one write cycle after space frees
// - almost-full releases one write cycle after level drops below threshold
// - almost-full changes only on write edges or a partial reset
// - standard retransmit ends with empty flag high; reader waits for it
// - fall-through retransmit ends with output-ready low after latency and two edges
// - fall-through counts the output register, depth one word larger
// - serial offsets span bits zero to fourteen for this depth
// - output-ready low enables write into next chained device
// - empty chain ripple time set by per-device latency
// - ripple delay only hits the first word into empty chain
// - freed space bubbles forward via input-ready going low
// - fall-through: output-ready falls together with valid first word
// - fall-through: input-ready low while space exists, high when none
module dual_clock_fifo
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// write side
	input  wire logic        wr_edge_in,
	input  wire logic        wr_en_n_in,
	input  wire logic [17:0] wr_data_in,
	// read side
	input  wire logic        rd_edge_in,
	input  wire logic        rd_en_n_in,
	output logic      [17:0] rd_data_out,
	// status flags, active low
	output logic             empty_flag_n_out,
	output logic             output_ready_n_out,
	output logic             full_flag_n_out,
	output logic             input_space_avail_n_out,
	output logic             almost_empty_flag_n_out,
	output logic             almost_full_flag_n_out,
	output logic             half_full_flag_n_out,
	// serial offset load
	input  wire logic        offset_load_n_in,
	input  wire logic        serial_en_n_in,
	input  wire logic        serial_in,
	// apb slave
	input  wire logic [11:0] paddr_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out
);

	logic [17:0] mem_q [32768];
	logic [15:0] wptr_q, wptr_d, rptr_q, rptr_d, rview, wview1, wview2, wlvl, rlvl, af_thr;
	logic [15:0] wlat_q [dcfifo_pkg::LAT_CYC];
	logic [15:0] wlat_d [dcfifo_pkg::LAT_CYC];
	logic        full_q, full_d, af_q, af_d, hf_q, hf_d, wr_take;
	logic        empty_q, empty_d, ae_q, ae_d, ov_q, ov_d, rd_take, load, rd_live;
	logic [17:0] rd_data_q, rd_data_d;
	logic        fall_through_mode_q, fall_through_mode_d, ser_mode_q, prst_q, prst_d, retx_req_q, retx_req_d;
	logic [14:0] ae_off_q, ae_off_d, af_off_q, af_off_d;
	logic [4:0]  ser_idx_q, ser_idx_d;
	logic [31:0] prdata_q, prdata_d;
	logic        apb_write, retx_go, retx_done;
	logic [1:0]  retx_cnt_q, retx_cnt_d, retx_target;
	dcfifo_pkg::retx_state_t retx_q, retx_d;

	// address decode for the error answer; the read mux decodes with its own case
	function automatic logic reg_known(input logic [11:0] addr);
		return (addr == dcfifo_pkg::ADDR_CTRL) || (addr == dcfifo_pkg::ADDR_AE_OFF) ||
			(addr == dcfifo_pkg::ADDR_AF_OFF) || (addr == dcfifo_pkg::ADDR_STATUS) ||
			(addr == dcfifo_pkg::ADDR_LEVEL);
	endfunction

	// each side sees the other's pointer one of its own edges late, the read side two in fall-through
	ptr_view u_rview  (.clk_in(clk_in), .rst_n_in(rst_n_in), .clear_in(prst_q), .sample_in(wr_edge_in),
		.ptr_in(rptr_q), .ptr_out(rview));
	ptr_view u_wview1 (.clk_in(clk_in), .rst_n_in(rst_n_in), .clear_in(prst_q), .sample_in(rd_edge_in),
		.ptr_in(wlat_q[dcfifo_pkg::LAT_CYC-1]), .ptr_out(wview1));
	ptr_view u_wview2 (.clk_in(clk_in), .rst_n_in(rst_n_in), .clear_in(prst_q), .sample_in(rd_edge_in),
		.ptr_in(wview1), .ptr_out(wview2));

	// fixed first-word latency, the write pointer reaches the read side late
	always_comb
	begin
		wlat_d[0] = wptr_q;
		for (int i = 1; i < dcfifo_pkg::LAT_CYC; i++)
			wlat_d[i] = wlat_q[i-1];
	end

	always_ff @(posedge clk_in)
	begin
		for (int i = 0; i < dcfifo_pkg::LAT_CYC; i++)
			wlat_q[i] <= rst_n_in ? wlat_d[i] : 16'h0000;
	end

	// storage array, no reset needed
	always_ff @(posedge clk_in)
	begin
		if (wr_take)
			mem_q[wptr_q[14:0]] <= wr_data_in;
	end

	// write side: pointer, write-edge flags, and the half-full flag updated every cycle
	assign af_thr = dcfifo_pkg::DEPTH - {1'b0, af_off_q};
	always_comb
	begin
		wr_take = wr_edge_in & ~wr_en_n_in & ~full_q;
		wptr_d  = wptr_q;
		full_d  = full_q;
		af_d    = af_q;
		wlvl    = dcfifo_pkg::fill_level(wptr_q, rview);
		if (prst_q)
		begin
			wptr_d = 16'h0000;
			full_d = 1'b0;
			af_d   = 1'b0;
		end
		else if (wr_edge_in)
		begin
			wptr_d = wptr_q + {15'h0000, wr_take};
			wlvl   = dcfifo_pkg::fill_level(wptr_d, rview);
			full_d = (wlvl >= dcfifo_pkg::DEPTH);
			af_d   = (wlvl >= af_thr);
		end
		hf_d = (dcfifo_pkg::fill_level(wptr_d, rptr_d) > dcfifo_pkg::HALF_DEPTH);
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			wptr_q <= 16'h0000;
			full_q <= 1'b0;
			af_q   <= 1'b0;
			hf_q   <= 1'b0;
		end
		else
		begin
			wptr_q <= wptr_d;
			full_q <= full_d;
			af_q   <= af_d;
			hf_q   <= hf_d;
		end
	end

	// retransmit sequencer: latency wait then a mode-dependent count of read edges
	assign retx_target = fall_through_mode_q ? dcfifo_pkg::RETX_EDGES_FALL_THROUGH_MODE : dcfifo_pkg::RETX_EDGES_STD;
	assign retx_go     = retx_req_q & ~prst_q & (retx_q == dcfifo_pkg::RETX_IDLE);
	assign retx_done   = (retx_q == dcfifo_pkg::RETX_EDGE) & rd_edge_in & (retx_cnt_q == retx_target - 2'h1);
	assign rd_live     = ((retx_q == dcfifo_pkg::RETX_IDLE) & ~retx_go) | retx_done;
	always_comb
	begin
		retx_d     = retx_q;
		retx_cnt_d = retx_cnt_q;
		case (retx_q)
			dcfifo_pkg::RETX_IDLE:
			begin
				retx_cnt_d = 2'h0;
				if (retx_go)
					retx_d = dcfifo_pkg::RETX_WAIT;
			end
			dcfifo_pkg::RETX_WAIT:
			begin
				retx_cnt_d = retx_cnt_q + 2'h1;
				if (retx_cnt_q == dcfifo_pkg::LAT_LAST)
				begin
					retx_d     = dcfifo_pkg::RETX_EDGE;
					retx_cnt_d = 2'h0;
				end
			end
			dcfifo_pkg::RETX_EDGE:
			begin
				if (retx_done)
					retx_d = dcfifo_pkg::RETX_IDLE;
				else if (rd_edge_in)
					retx_cnt_d = retx_cnt_q + 2'h1;
			end
			default:
			begin
				retx_d     = dcfifo_pkg::RETX_IDLE;
				retx_cnt_d = 2'h0;
			end
		endcase
		if (prst_q)
			retx_d = dcfifo_pkg::RETX_IDLE;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			retx_q     <= dcfifo_pkg::RETX_IDLE;
			retx_cnt_q <= 2'h0;
		end
		else
		begin
			retx_q     <= retx_d;
			retx_cnt_q <= retx_cnt_d;
		end
	end

	// read side: pointer, output register and read-edge flags
	always_comb
	begin
		rd_take   = rd_edge_in & ~rd_en_n_in & (fall_through_mode_q ? ov_q : ~empty_q) & (retx_q == dcfifo_pkg::RETX_IDLE);
		load      = 1'b0;
		rptr_d    = rptr_q;
		ov_d      = ov_q;
		empty_d   = empty_q;
		ae_d      = ae_q;
		rd_data_d = rd_data_q;
		rlvl      = 16'h0000;
		if (prst_q || retx_go)
		begin
			rptr_d  = 16'h0000;
			ov_d    = 1'b0;
			empty_d = 1'b1;
			ae_d    = 1'b1;
		end
		else if (rd_edge_in && rd_live && fall_through_mode_q)
		begin
			// the output register is filled without a read, so a chain ripples forward
			load = (dcfifo_pkg::fill_level(wview2, rptr_q) != 16'h0000) & (~ov_q | rd_take);
			rptr_d = rptr_q + {15'h0000, load};
			if (load)
				rd_data_d = mem_q[rptr_q[14:0]];
			ov_d    = load | (ov_q & ~rd_take);
			empty_d = (dcfifo_pkg::fill_level(wview2, rptr_d) == 16'h0000);
			rlvl    = dcfifo_pkg::fill_level(wview2, rptr_d) + {15'h0000, ov_d};
			ae_d    = (rlvl <= {1'b0, ae_off_q} + 16'h0001);
		end
		else if (rd_edge_in && rd_live)
		begin
			rptr_d = rptr_q + {15'h0000, rd_take};
			if (rd_take)
				rd_data_d = mem_q[rptr_q[14:0]];
			rlvl    = dcfifo_pkg::fill_level(wview1, rptr_d);
			empty_d = (rlvl == 16'h0000);
			ae_d    = (rlvl <= {1'b0, ae_off_q});
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			rptr_q    <= 16'h0000;
			ov_q      <= 1'b0;
			empty_q   <= 1'b1;
			ae_q      <= 1'b1;
			rd_data_q <= 18'h00000;
		end
		else
		begin
			rptr_q    <= rptr_d;
			ov_q      <= ov_d;
			empty_q   <= empty_d;
			ae_q      <= ae_d;
			rd_data_q <= rd_data_d;
		end
	end

	// configuration: apb writes, serial offset shift, read data staged in setup
	assign apb_write = psel_in & penable_in & pwrite_in;
	always_comb
	begin
		fall_through_mode_d     = fall_through_mode_q;
		ae_off_d   = ae_off_q;
		af_off_d   = af_off_q;
		ser_idx_d  = ser_idx_q;
		prst_d     = 1'b0;
		retx_req_d = 1'b0;
		prdata_d   = prdata_q;
		if (apb_write && paddr_in == dcfifo_pkg::ADDR_CTRL)
		begin
			fall_through_mode_d     = pwdata_in[dcfifo_pkg::CTRL_FALL_THROUGH_MODE];
			prst_d     = pwdata_in[dcfifo_pkg::CTRL_PRST];
			retx_req_d = pwdata_in[dcfifo_pkg::CTRL_RETX];
		end
		if (apb_write && paddr_in == dcfifo_pkg::ADDR_AE_OFF)
			ae_off_d = pwdata_in[14:0];
		if (apb_write && paddr_in == dcfifo_pkg::ADDR_AF_OFF)
			af_off_d = pwdata_in[14:0];
		// serial walks bits 0..14 of the empty offset, then of the full offset
		if (offset_load_n_in || !ser_mode_q)
			ser_idx_d = 5'h00;
		else if (wr_edge_in && !serial_en_n_in)
		begin
			if (ser_idx_q < dcfifo_pkg::SER_SPLIT)
				ae_off_d[ser_idx_q[3:0]] = serial_in;
			else
				af_off_d[4'(ser_idx_q - dcfifo_pkg::SER_SPLIT)] = serial_in;
			ser_idx_d = (ser_idx_q == dcfifo_pkg::SER_LAST) ? 5'h00 : ser_idx_q + 5'h01;
		end
		if (psel_in && !penable_in)
		begin
			case (paddr_in)
				dcfifo_pkg::ADDR_CTRL:   prdata_d = {31'h00000000, fall_through_mode_q};
				dcfifo_pkg::ADDR_AE_OFF: prdata_d = {17'h00000, ae_off_q};
				dcfifo_pkg::ADDR_AF_OFF: prdata_d = {17'h00000, af_off_q};
				dcfifo_pkg::ADDR_STATUS: prdata_d = {25'h0000000, (retx_q != dcfifo_pkg::RETX_IDLE), ov_q, hf_q, af_q,
					ae_q, full_q, empty_q};
				dcfifo_pkg::ADDR_LEVEL:  prdata_d = {16'h0000, dcfifo_pkg::fill_level(wptr_q, rptr_q)};
				default:                 prdata_d = 32'h00000000;
			endcase
		end
	end

	// load strap picks default offsets and the serial method while reset is held
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			fall_through_mode_q     <= dcfifo_pkg::CTRL_FALL_THROUGH_MODE_RST;
			ser_mode_q <= offset_load_n_in;
			ae_off_q   <= offset_load_n_in ? dcfifo_pkg::OFF_DEF_SER : dcfifo_pkg::OFF_DEF_PAR;
			af_off_q   <= offset_load_n_in ? dcfifo_pkg::OFF_DEF_SER : dcfifo_pkg::OFF_DEF_PAR;
			ser_idx_q  <= 5'h00;
			prst_q     <= 1'b0;
			retx_req_q <= 1'b0;
			prdata_q   <= 32'h00000000;
		end
		else
		begin
			fall_through_mode_q     <= fall_through_mode_d;
			ae_off_q   <= ae_off_d;
			af_off_q   <= af_off_d;
			ser_idx_q  <= ser_idx_d;
			prst_q     <= prst_d;
			retx_req_q <= retx_req_d;
			prdata_q   <= prdata_d;
		end
	end

	// pins; of the four mode flags only the pair belonging to the current mode is live
	assign rd_data_out             = rd_data_q;
	assign empty_flag_n_out        = fall_through_mode_q | ~empty_q;
	assign output_ready_n_out      = ~fall_through_mode_q | ~ov_q;
	assign full_flag_n_out         = fall_through_mode_q | ~full_q;
	assign input_space_avail_n_out = ~fall_through_mode_q | full_q;
	assign almost_empty_flag_n_out = ~ae_q;
	assign almost_full_flag_n_out  = ~af_q;
	assign half_full_flag_n_out    = ~hf_q;
	assign prdata_out              = prdata_q;
	assign pready_out              = 1'b1;
	assign pslverr_out             = psel_in & penable_in & ~reg_known(paddr_in);

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_full_release_std;
		!fall_through_mode_q && !prst_q && wr_edge_in && full_q && wr_en_n_in && dcfifo_pkg::fill_level(wptr_q, rview) < dcfifo_pkg::DEPTH |=> !full_q;
	endproperty
	a_full_release_std: assert property (p_full_release_std) else $error("full flag not released");
	property p_ir_release_fall_through_mode;
		fall_through_mode_q && !prst_q && wr_edge_in && full_q && wr_en_n_in && dcfifo_pkg::fill_level(wptr_q, rview) < dcfifo_pkg::DEPTH |=> !input_space_avail_n_out;
	endproperty
	a_ir_release_fall_through_mode: assert property (p_ir_release_fall_through_mode) else $error("input ready not asserted");
	property p_empty_release;
		!fall_through_mode_q && !prst_q && rd_edge_in && rd_live && dcfifo_pkg::fill_level(wview1, rptr_d) != 16'h0000 |=> !empty_q;
	endproperty
	a_empty_release: assert property (p_empty_release) else $error("empty flag not released");
	property p_latency;
		wlat_q[dcfifo_pkg::LAT_CYC-1] == $past(wptr_q);
	endproperty
	a_latency: assert property (p_latency) else $error("first word latency stage wrong");
	property p_ae_release;
		!fall_through_mode_q && !prst_q && rd_edge_in && rd_live && dcfifo_pkg::fill_level(wview1, rptr_d) > {1'b0, ae_off_q} |=> !ae_q;
	endproperty
	a_ae_release: assert property (p_ae_release) else $error("almost empty not released");
	property p_af_release;
		wr_edge_in && !prst_q && dcfifo_pkg::fill_level(wptr_d, rview) < af_thr |=> !af_q ##1 (af_q == $past(af_q) || $past(wr_edge_in) || $past(prst_q));
	endproperty
	a_af_release: assert property (p_af_release) else $error("almost full not released");
	property p_af_wr_edge_only;
		!$stable(af_q) |-> $past(wr_edge_in) || $past(prst_q);
	endproperty
	a_af_wr_edge_only: assert property (p_af_wr_edge_only) else $error("almost full moved off a write edge");
	property p_retx_start;
		retx_go |=> empty_q && !ov_q && rptr_q == 16'h0000 && retx_q == dcfifo_pkg::RETX_WAIT;
	endproperty
	a_retx_start: assert property (p_retx_start) else $error("retransmit did not start");
	property p_retx_end;
		retx_done |=> retx_q == dcfifo_pkg::RETX_IDLE;
	endproperty
	a_retx_end: assert property (p_retx_end) else $error("retransmit did not finish");
	property p_full_at_depth;
		wr_edge_in && !prst_q && dcfifo_pkg::fill_level(wptr_d, rview) == dcfifo_pkg::DEPTH |=> full_q;
	endproperty
	a_full_at_depth: assert property (p_full_at_depth) else $error("full not raised at depth");
	property p_ser_range;
		ser_idx_q <= dcfifo_pkg::SER_LAST;
	endproperty
	a_ser_range: assert property (p_ser_range) else $error("serial index out of range");
	property p_ov_with_data;
		$rose(ov_q) |-> rptr_q == $past(rptr_q) + 16'h0001 && rd_data_q == $past(mem_q[rptr_q[14:0]]);
	endproperty
	a_ov_with_data: assert property (p_ov_with_data) else $error("output ready without its word");
	property p_write_ignored;
		wr_edge_in && !wr_en_n_in && full_q && !prst_q |=> wptr_q == $past(wptr_q);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("write taken while full");
	property p_read_ignored;
		!fall_through_mode_q && rd_edge_in && !rd_en_n_in && empty_q && !prst_q && !retx_go |=> rptr_q == $past(rptr_q);
	endproperty
	a_read_ignored: assert property (p_read_ignored) else $error("read taken while empty");

	c_full:     cover property (full_q && !fall_through_mode_q);
	c_ov:       cover property ($rose(ov_q));
	c_retx:     cover property (retx_done);
	c_ser_last: cover property (ser_idx_q == dcfifo_pkg::SER_LAST);

endmodule

// File: test/edge_source.sv
`timescale 1ns/1ps
// far side: write and read clocks of the producer and consumer, seen as edge pulses
module edge_source
(
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// periods in clk_in cycles, at least 1
	input  wire logic [3:0] wr_per_in,
	input  wire logic [3:0] rd_per_in,
	// edge pulses
	output logic            wr_edge_out,
	output logic            rd_edge_out
);
	logic [3:0] wc_q;
	logic [3:0] rc_q;

	// both clocks run freely, also while nothing is transferred
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			wc_q        <= 4'h0;
			rc_q        <= 4'h0;
			wr_edge_out <= 1'b0;
			rd_edge_out <= 1'b0;
		end
		else
		begin
			wc_q        <= (wc_q + 4'h1 >= wr_per_in) ? 4'h0 : wc_q + 4'h1;
			rc_q        <= (rc_q + 4'h1 >= rd_per_in) ? 4'h0 : rc_q + 4'h1;
			wr_edge_out <= (wc_q == 4'h0);
			rd_edge_out <= (rc_q == 4'h0);
		end
	end
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
	logic        clk_in = 1'b0, rst_n_in = 1'b0;
	logic        wr_edge_in, rd_edge_in, wr_en_n_in = 1'b1, rd_en_n_in = 1'b1;
	logic [17:0] wr_data_in = 18'h00000, rd_data_out;
	logic        empty_flag_n_out, output_ready_n_out, full_flag_n_out, input_space_avail_n_out;
	logic        almost_empty_flag_n_out, almost_full_flag_n_out, half_full_flag_n_out;
	logic [11:0] paddr_in = 12'h000;
	logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, pready_out, pslverr_out;
	logic [31:0] pwdata_in = 32'h00000000, prdata_out, rdv;
	logic [3:0]  wr_per = 4'h3, rd_per = 4'h5;
	logic        ld_n = 1'b1, sen_n = 1'b1, sin = 1'b0;
	logic [29:0] ser;
	logic        err, fall_through_mode = 1'b0, rd_pend = 1'b0, or_prev = 1'b1, af_watch = 1'b0, af_prev = 1'b1, wr_prev;
	int          error_cnt = 0, n_checks = 0, cycles = 0, seed = 32'h10042299, n;
	logic [17:0] exp_q[$], w[3];

	// strap high at reset selects the larger defaults and the serial method
	// a wider build would share every one of these control lines
	edge_source edge_source_i (.clk_in, .rst_n_in, .wr_per_in(wr_per), .rd_per_in(rd_per),
		.wr_edge_out(wr_edge_in), .rd_edge_out(rd_edge_in));
	dual_clock_fifo dual_clock_fifo_i (.clk_in, .rst_n_in, .wr_edge_in, .wr_en_n_in, .wr_data_in,
		.rd_edge_in, .rd_en_n_in, .rd_data_out, .empty_flag_n_out, .output_ready_n_out,
		.full_flag_n_out, .input_space_avail_n_out, .almost_empty_flag_n_out, .almost_full_flag_n_out,
		.half_full_flag_n_out, .offset_load_n_in(ld_n), .serial_en_n_in(sen_n), .serial_in(sin),
		.paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out);

	always #50 clk_in = ~clk_in;

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the sequence needs
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			error_cnt++;
			complete_run();
		end
	end

	// apb master: setup, access, hold until pready at an edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk_in);
		psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= wr; paddr_in <= a; pwdata_in <= wd;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rdv = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0; penable_in <= 1'b0;
	endtask

	// enables held until a far-side edge has taken them
	task wr_word(input logic [17:0] d);
		@(posedge clk_in);
		wr_en_n_in <= 1'b0; wr_data_in <= d;
		do @(posedge clk_in); while (wr_edge_in !== 1'b1);
		wr_en_n_in <= 1'b1;
		exp_q.push_back(d);
	endtask

	task rd_word;
		@(posedge clk_in);
		rd_en_n_in <= 1'b0;
		do @(posedge clk_in); while (rd_edge_in !== 1'b1);
		rd_en_n_in <= 1'b1;
	endtask

	task wait_edges(input logic rd, input int k);
		repeat (k) do @(posedge clk_in); while ((rd ? rd_edge_in : wr_edge_in) !== 1'b1);
		@(posedge clk_in);
	endtask

	// read edges seen until empty rises (sel 0) or output-ready falls (sel 1)
	task edges_until(input logic sel, output int k);
		logic hit;
		k = 0;
		hit = 1'b0;
		while (!hit)
		begin
			@(posedge clk_in);
			hit = sel ? (output_ready_n_out === 1'b0) : (empty_flag_n_out === 1'b1);
			if (!hit && rd_edge_in === 1'b1)
				k++;
		end
	endtask

	// monitor: each read result takes the oldest noted word
	always @(posedge clk_in)
	begin
		if (rd_pend || (fall_through_mode && or_prev && output_ready_n_out === 1'b0))
			chk(32'(rd_data_out), exp_q.size() ? 32'(exp_q.pop_front()) : 32'h0003FFFF);
		rd_pend = rd_edge_in && !rd_en_n_in && empty_flag_n_out === 1'b1 && !fall_through_mode;
		or_prev = output_ready_n_out;
		if (af_watch && almost_full_flag_n_out !== af_prev && wr_prev !== 1'b1)
			chk(32'h0, 32'h1);
		af_prev = almost_full_flag_n_out;
		wr_prev = wr_edge_in;
	end

	initial
	begin
		repeat (6) @(posedge clk_in);
		chk({empty_flag_n_out, almost_empty_flag_n_out, full_flag_n_out, almost_full_flag_n_out,
			half_full_flag_n_out, output_ready_n_out, input_space_avail_n_out}, 32'h0000001F);
		chk(32'(rd_data_out), 32'h00000000);
		rst_n_in <= 1'b1;
		apb(1'b0, dcfifo_pkg::ADDR_CTRL, 32'h0);
		chk(rdv, 32'h00000000);
		// serial load with the strap low: empty offset bits first, then the full offset
		ser = 30'($random(seed));
		ld_n <= 1'b0;
		sen_n <= 1'b0;
		for (int i = 0; i < 30; i++)
		begin
			sin <= ser[i];
			do @(posedge clk_in); while (wr_edge_in !== 1'b1);
		end
		ld_n <= 1'b1;
		sen_n <= 1'b1;
		apb(1'b0, dcfifo_pkg::ADDR_AE_OFF, 32'h0);
		chk(rdv, {17'h00000, ser[14:0]});
		apb(1'b0, dcfifo_pkg::ADDR_AF_OFF, 32'h0);
		chk(rdv, {17'h00000, ser[29:15]});
		apb(1'b1, dcfifo_pkg::ADDR_AE_OFF, 32'h00000002);
		apb(1'b1, dcfifo_pkg::ADDR_AF_OFF, 32'h00007FFF);
		apb(1'b0, dcfifo_pkg::ADDR_AE_OFF, 32'h0);
		chk(rdv, 32'h00000002);
		apb(1'b0, 12'h020, 32'h0);
		chk({rdv[30:0], err}, 32'h00000001);
		apb(1'b0, dcfifo_pkg::ADDR_STATUS, 32'h0);
		chk(rdv, (32'h1 << dcfifo_pkg::ST_EMPTY) | (32'h1 << dcfifo_pkg::ST_AE));
		rd_word();
		wait_edges(1'b1, 2);
		chk(32'(rd_data_out), 32'h00000000);
		// standard mode: three words only, well below depth minus two
		af_watch = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			w[i] = 18'($random(seed));
			wr_word(w[i]);
			if (i == 0)
			begin
				@(posedge clk_in);
				chk(32'(almost_full_flag_n_out), 32'h0);
				edges_until(1'b0, n);
				chk(32'(n >= 2 && n <= 3), 32'h1);
			end
		end
		wait_edges(1'b1, 4);
		chk(32'(almost_empty_flag_n_out), 32'h1);
		repeat (3) rd_word();
		wait_edges(1'b0, 4);
		chk(32'(almost_full_flag_n_out), 32'h1);
		af_watch = 1'b0;
		apb(1'b1, dcfifo_pkg::ADDR_CTRL, 32'h00000004);
		@(posedge clk_in);
		chk(32'(empty_flag_n_out), 32'h0);
		foreach (w[i]) exp_q.push_back(w[i]);
		edges_until(1'b0, n);
		chk(32'(n >= 1 && n <= 3), 32'h1);
		repeat (3) rd_word();
		wait_edges(1'b1, 2);
		chk(32'(exp_q.size()), 32'h0);
		// fall-through mode after a partial reset
		apb(1'b1, dcfifo_pkg::ADDR_CTRL, 32'h00000003);
		fall_through_mode = 1'b1;
		apb(1'b0, dcfifo_pkg::ADDR_CTRL, 32'h0);
		chk(rdv, 32'h00000001);
		@(posedge clk_in);
		chk({empty_flag_n_out, input_space_avail_n_out}, 32'h00000002);
		for (int i = 0; i < 3; i++)
		begin
			wr_per <= 4'h1 + 4'($unsigned($random(seed)) % 7);
			rd_per <= 4'h1 + 4'($unsigned($random(seed)) % 7);
			w[i] = 18'($random(seed));
			wr_word(w[i]);
			edges_until(1'b1, n);
			chk(32'(n >= 3 && n <= 4), 32'h1);
			rd_word();
			wait_edges(1'b1, 2);
			chk({output_ready_n_out, rd_data_out}, {13'h0001, w[i]});
		end
		apb(1'b1, dcfifo_pkg::ADDR_CTRL, 32'h00000005);
		@(posedge clk_in);
		chk(32'(output_ready_n_out), 32'h1);
		exp_q.push_back(w[0]);
		edges_until(1'b1, n);
		chk(32'(n >= 2 && n <= 5), 32'h1);
		@(posedge clk_in);
		chk(32'(exp_q.size()), 32'h0);
		complete_run();
	end
endmodule
